// [dv/tb_top.sv]
`timescale 1ns/10ps
`define CHK(w, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", w, e, g); \
    end \
  end
// ********
// Bench top
// ********
module tb_top
  import usb_common_pkg::*;
;
  localparam int DEPTH = 4;
  localparam int E_SUSP = 0, E_RES = 1, E_BAB = 2, E_SOF = 3, E_CONN = 4, E_DISC = 5;
  localparam int E_SREQ = 6, E_DROP = 7, E_SEND = 8, E_TXL = 9, E_IN = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] wdata = '0;
  logic host = 1'b0;
  logic a_dev = 1'b0;
  logic [7:0] rdata, d;
  logic rvalid, ep_ready, send_pkt, send_zero, line_en, hs_allow, resume_out, susp_n, irq;
  logic bus_rst, chirp, ep_valid, ep_rx;
  logic [10:0] evt, frame;
  logic [3:0] ep_num;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [9:0] ra [13] = '{10'h006, 10'h007, 10'h008, 10'h009, 10'h00b, 10'h000, 10'h001,
                          10'h07a, 10'h07c, 10'h07e, 10'h302, 10'h303, 10'h00a};
  logic [7:0] rv [13] = '{8'hff, 8'hff, 8'hfe, 8'hff, 8'h06, 8'h00, 8'h20,
                          8'h5c, 8'h80, 8'h72, 8'h00, 8'h00, 8'h00};

  usb_common_ctrl #(.FIFO_DEPTH(DEPTH)) usb_common_ctrl_i (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WR_I(wr_s), .RD_I(rd_s),
    .WDATA_I(wdata), .RDATA_O(rdata), .RVALID_O(rvalid), .HOST_MODE_I(host),
    .A_DEVICE_I(a_dev), .BUS_RESET_I(bus_rst), .HS_CHIRP_OK_I(chirp),
    .RESUME_DET_I(evt[E_RES]), .SUSPEND_DET_I(evt[E_SUSP]), .SUPPLY_DROP_I(evt[E_DROP]),
    .SESSION_REQ_I(evt[E_SREQ]), .DISCONNECT_I(evt[E_DISC]), .SESSION_END_I(evt[E_SEND]),
    .CONNECT_I(evt[E_CONN]), .BABBLE_I(evt[E_BAB]), .SOF_I(evt[E_SOF]), .FRAME_NUM_I(frame),
    .TX_PACKET_LOADED_I(evt[E_TXL]), .IN_TOKEN_I(evt[E_IN]), .EP_EVT_VALID_I(ep_valid),
    .EP_EVT_RX_I(ep_rx), .EP_EVT_NUM_I(ep_num), .EP_EVT_READY_O(ep_ready),
    .SEND_PACKET_O(send_pkt), .SEND_ZERO_LEN_O(send_zero), .LINE_DRV_EN_O(line_en),
    .HIGH_SPEED_ALLOW_O(hs_allow), .RESUME_OUT_O(resume_out), .PHY_SUSPEND_OUT_N_O(susp_n),
    .IRQ_O(irq)
  );
  usb_far_end_model usb_far_end_model_i (
    .clk_i(clk), .ep_ready_i(ep_ready), .evt_o(evt), .bus_rst_o(bus_rst), .chirp_o(chirp),
    .frame_o(frame), .ep_valid_o(ep_valid), .ep_rx_o(ep_rx), .ep_num_o(ep_num)
  );

  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  // Register access tasks
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic wr_wait(input logic [9:0] a, input logic [7:0] v);
    wr(a, v);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("read answer", 1'b1, rvalid)
    v = rdata;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK($sformatf("register %h", a), e, v)
  endtask
  // Bus event, then interrupt line and common flags
  task automatic evt_chk(input int e, input logic [7:0] x);
    usb_far_end_model_i.pulse(e, 11'h000);
    @(posedge clk);
    #1;
    `CHK("irq", |x, irq)
    rd_chk(OFS_USB_FLAGS, x);
  endtask
  // Packet readied, optional frame start, then IN token
  task automatic iso(input logic sof, input logic zero);
    usb_far_end_model_i.pulse(E_TXL, 11'h000);
    if (sof) begin
      usb_far_end_model_i.pulse(E_SOF, 11'h000);
    end
    usb_far_end_model_i.pulse(E_IN, 11'h000);
    #1;
    `CHK("zero length", zero, send_zero)
    `CHK("packet", !zero, send_pkt)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd_chk(ra[i], rv[i]);
    end
    wr(OFS_FUNCTION_ADDRESS, 8'hff);
    rd_chk(OFS_FUNCTION_ADDRESS, 8'h7f);
    wr(OFS_RX_EN, 8'hff);
    rd_chk(OFS_RX_EN, 8'hfe);
    wr(OFS_TX_EN + 10'h001, 8'h5a);
    rd_chk(OFS_TX_EN + 10'h001, 8'h5a);
    wr(OFS_RQ_COUNT + 10'h01e, 8'h34);
    rd_chk(OFS_RQ_COUNT + 10'h01e, 8'h34);
    wr(OFS_FRAME, 8'hff);
    rd_chk(OFS_FRAME, 8'h00);
    wr(10'h070, 8'hff);
    rd_chk(10'h070, 8'h00);
    wr(OFS_TX_EN + 10'h001, 8'hff);
    $display("test registers done");
    usb_far_end_model_i.ep_send(1'b0, 4'd0);
    usb_far_end_model_i.ep_send(1'b0, 4'd15);
    usb_far_end_model_i.ep_send(1'b1, 4'd0);
    usb_far_end_model_i.ep_send(1'b1, 4'd1);
    usb_far_end_model_i.ep_send(1'b1, 4'd15);
    repeat (4) @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    rd_chk(OFS_TX_FLAGS, 8'h01);
    rd_chk(OFS_TX_FLAGS + 10'h001, 8'h80);
    rd_chk(OFS_RX_FLAGS, 8'h02);
    rd_chk(OFS_RX_FLAGS + 10'h001, 8'h80);
    wr_wait(OFS_TX_EN, 8'h00);
    `CHK("irq", 1'b0, irq)
    usb_far_end_model_i.ep_send(1'b0, 4'd2);
    repeat (4) @(posedge clk);
    #1;
    `CHK("irq", 1'b0, irq)
    rd_chk(OFS_TX_FLAGS, 8'h04);
    wr(OFS_TX_EN, 8'hff);
    // Hold flag reads so the buffer cannot drain, then fill it
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= OFS_TX_FLAGS;
    for (int i = 0; i < DEPTH; i++) begin
      usb_far_end_model_i.ep_send(1'b0, 4'(4 + i));
    end
    @(posedge clk);
    #1;
    `CHK("ready", 1'b0, ep_ready)
    @(posedge clk);
    rd_s <= 1'b0;
    repeat (DEPTH + 4) @(posedge clk);
    #1;
    `CHK("ready", 1'b1, ep_ready)
    rd_chk(OFS_TX_FLAGS, 8'hf0);
    $display("test endpoints done");
    wr(OFS_USB_EN, 8'hff);
    rd_chk(OFS_USB_EN, 8'hff);
    a_dev <= 1'b1;
    evt_chk(E_DROP, 8'h80);
    evt_chk(E_SREQ, 8'h40);
    evt_chk(E_SEND, 8'h20);
    evt_chk(E_CONN, 8'h00);
    evt_chk(E_SOF, 8'h08);
    usb_far_end_model_i.set_reset(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(OFS_POWER, 8'h28);
    usb_far_end_model_i.set_reset(1'b0, 1'b1);
    rd_chk(OFS_POWER, 8'h30);
    rd_chk(OFS_USB_FLAGS, 8'h04);
    wr_wait(OFS_POWER, 8'h00);
    `CHK("speed allow", 1'b0, hs_allow)
    usb_far_end_model_i.set_reset(1'b1, 1'b1);
    usb_far_end_model_i.set_reset(1'b0, 1'b1);
    rd_chk(OFS_POWER, 8'h00);
    rd_chk(OFS_USB_FLAGS, 8'h04);
    wr_wait(OFS_POWER, 8'h41);
    `CHK("line drive", 1'b1, line_en)
    usb_far_end_model_i.pulse(E_SUSP, 11'h000);
    rd_chk(OFS_POWER, 8'h43);
    `CHK("suspend out", 1'b0, susp_n)
    usb_far_end_model_i.pulse(E_RES, 11'h000);
    rd_chk(OFS_USB_FLAGS, 8'h03);
    rd_chk(OFS_POWER, 8'h41);
    `CHK("suspend out", 1'b1, susp_n)
    wr_wait(OFS_POWER, 8'h04);
    `CHK("resume out", 1'b1, resume_out)
    `CHK("line drive", 1'b0, line_en)
    wr(OFS_POWER, 8'h80);
    iso(1'b0, 1'b1);
    iso(1'b1, 1'b0);
    wr(OFS_POWER, 8'h00);
    iso(1'b0, 1'b0);
    $display("test peripheral done");
    // Second reset in mid-run, then host operation
    @(posedge clk);
    rst <= 1'b1;
    host <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_USB_EN, 8'h06);
    wr(OFS_USB_EN, 8'hff);
    rd_chk(OFS_DEV_CTL, 8'h04);
    evt_chk(E_BAB, 8'h00);
    evt_chk(E_SUSP, 8'h00);
    usb_far_end_model_i.pulse(E_SOF, 11'h5a5);
    rd_chk(OFS_FRAME, 8'ha5);
    rd_chk(OFS_FRAME + 10'h001, 8'h05);
    evt_chk(E_BAB, 8'h0c);
    evt_chk(E_CONN, 8'h10);
    evt_chk(E_DISC, 8'h20);
    wr(OFS_POWER, 8'h02);
    usb_far_end_model_i.pulse(E_RES, 11'h000);
    rd(OFS_POWER, d);
    `CHK("resume bit", 8'h04, d & 8'h04)
    rd_chk(OFS_USB_FLAGS, 8'h02);
    wr(OFS_POWER, 8'h00);
    $display("test host done");
    results();
  end
endmodule

bind usb_common_ctrl usb_ctrl_checker chk_i (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WR_I(WR_I),
  .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
  .BUS_RESET_I(BUS_RESET_I), .IN_TOKEN_I(IN_TOKEN_I), .SEND_PACKET_O(SEND_PACKET_O),
  .SEND_ZERO_LEN_O(SEND_ZERO_LEN_O), .LINE_DRV_EN_O(LINE_DRV_EN_O),
  .HIGH_SPEED_ALLOW_O(HIGH_SPEED_ALLOW_O), .PHY_SUSPEND_OUT_N_O(PHY_SUSPEND_OUT_N_O)
);

// [dv/usb_ctrl_checker.sv]
`timescale 1ns/10ps
// ********
// Pin and register checks
// ********
module usb_ctrl_checker
  import usb_common_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [9:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic BUS_RESET_I,
  input wire logic IN_TOKEN_I,
  input wire logic SEND_PACKET_O,
  input wire logic SEND_ZERO_LEN_O,
  input wire logic LINE_DRV_EN_O,
  input wire logic HIGH_SPEED_ALLOW_O,
  input wire logic PHY_SUSPEND_OUT_N_O
);
  logic [7:0] pwr_w_r;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  // Last byte written to the power register
  always_ff @(posedge REF_CLK_I) begin
    if (WR_I && ADDR_I == OFS_POWER) begin
      pwr_w_r <= WDATA_I;
    end
  end
  // Read of one address; power write with a quiet cycle after it
  sequence rd_at(logic [9:0] a);
    RD_I && ADDR_I == a;
  endsequence
  sequence pwr_set;
    (WR_I && ADDR_I == OFS_POWER) ##1 !(WR_I && ADDR_I == OFS_POWER);
  endsequence
  sequence rst_read;
    BUS_RESET_I ##1 (BUS_RESET_I && RD_I && ADDR_I == OFS_POWER);
  endsequence
  AST_FUNCTION_ADDRESS_TOP: assert property (rd_at(OFS_FUNCTION_ADDRESS) |=> RVALID_O && !RDATA_O[7])
    else $error("address top bit not zero");
  AST_ISO_ANSWER: assert property (IN_TOKEN_I |=> SEND_PACKET_O != SEND_ZERO_LEN_O)
    else $error("no single answer to token");
  AST_ISO_QUIET: assert property (!IN_TOKEN_I |=> !SEND_PACKET_O && !SEND_ZERO_LEN_O)
    else $error("send without token");
  AST_LINE_DRIVE: assert property (pwr_set |=> LINE_DRV_EN_O == pwr_w_r[6])
    else $error("line drive not following power bit 6");
  AST_HS_ALLOW: assert property (pwr_set |=> HIGH_SPEED_ALLOW_O == pwr_w_r[5])
    else $error("speed allow not following power bit 5");
  AST_RESET_SEEN: assert property (rst_read |=> RDATA_O[3])
    else $error("reset status bit low during bus reset");
  AST_SUSP_OFF: assert property ((pwr_set ##0 !pwr_w_r[0]) |=> PHY_SUSPEND_OUT_N_O)
    else $error("suspend output low while disabled");
  AST_RX_FLAG0: assert property (rd_at(OFS_RX_FLAGS) |=> !RDATA_O[0])
    else $error("rx flag bit 0 set");
  AST_RX_EN0: assert property (rd_at(OFS_RX_EN) |=> !RDATA_O[0])
    else $error("rx enable bit 0 set");
  AST_FRAME_TOP: assert property (rd_at(OFS_FRAME + 10'h001) |=> RDATA_O[7:3] == 5'h00)
    else $error("frame top bits set");
endmodule

// [dv/usb_far_end_model.sv]
`timescale 1ns/10ps
// ********
// Far side of the link
// ********
module usb_far_end_model (
  input wire logic clk_i,
  input wire logic ep_ready_i,
  output logic [10:0] evt_o,
  output logic bus_rst_o,
  output logic chirp_o,
  output logic [10:0] frame_o,
  output logic ep_valid_o,
  output logic ep_rx_o,
  output logic [3:0] ep_num_o
);
  // Idle levels at time zero
  initial begin
    evt_o = '0;
    bus_rst_o = 1'b0;
    chirp_o = 1'b0;
    frame_o = '0;
    ep_valid_o = 1'b0;
    ep_rx_o = 1'b0;
    ep_num_o = '0;
  end
  // One-cycle event; frame number only meaningful with a frame start
  task automatic pulse(input int e, input logic [10:0] f);
    @(posedge clk_i);
    evt_o[e] <= 1'b1;
    frame_o <= f;
    @(posedge clk_i);
    evt_o[e] <= 1'b0;
    frame_o <= ~f;
  endtask
  // Reset signalling level with the chirp result beside it
  task automatic set_reset(input logic lvl, input logic ok);
    @(posedge clk_i);
    bus_rst_o <= lvl;
    chirp_o <= ok;
  endtask
  // Endpoint event held until taken, with a bounded wait
  task automatic ep_send(input logic rx, input logic [3:0] n);
    int k;
    k = 0;
    @(posedge clk_i);
    ep_valid_o <= 1'b1;
    ep_rx_o <= rx;
    ep_num_o <= n;
    do begin
      @(posedge clk_i);
      k++;
    end while (!ep_ready_i && k < 100);
    ep_valid_o <= 1'b0;
    ep_num_o <= ~n;
  endtask
endmodule

// [rtl/usb_common_ctrl.sv]
`timescale 1ns/10ps
// Functional notes
// - Address is 7 bits; bit 7 reads zero
// - Iso update holds packet until SOF; else zero-length
// - Soft connect bit enables or tri-states line drivers
// - High speed allow enables chirp negotiation at reset
// - High speed active latched at reset end
// - Reset status bit mirrors bus reset signalling
// - Host mode sets resume bit on resume detected while suspended
// - Suspend bit set, cleared by flag read or resume
// - Suspend output enable gates the transceiver suspend signal
// - Sixteen transmit endpoint flags, endpoint n at bit n
// - Receive flags endpoints 1-15, bit 0 zero
// - Sixteen writable transmit endpoint enables
// - Receive enables 1-15, bit 0 reads zero
// - Supply drop flag while A device
// - Session request flag while A device
// - Disconnect or session end; connect in host
// - Start of frame flag each new frame
// - Reset in peripheral, babble after first SOF
// - Resume while suspended; suspend in peripheral mode
// - Eight enables match the common event flags
// - Frame register holds last frame number
// - Requested packet counters per receive endpoint, reset zero
// - Endpoint enables reset to all ones, receive fffe
// - Common event enables reset to 06
// - Device control bit 2 reports host mode

// ********
// Event FIFO
// ********
module usb_event_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("FIFO depth must be a power of two of at least 2");
  end
  if (WIDTH < 1) begin : g_width_check
    $error("FIFO width must be at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_ready;
  } fifo_s;

  fifo_s q_r;
  fifo_s q_nxt;
  logic push;
  logic pop;

  // Push and pop decisions; ready is registered from the next count
  always_comb begin
    q_nxt = q_r;
    push = in_valid_i & q_r.in_ready;
    pop = out_ready_i & (q_r.count != '0);
    if (push) begin
      q_nxt.mem[q_r.wr_ptr] = in_data_i;
      q_nxt.wr_ptr = q_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      q_nxt.rd_ptr = q_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.count = q_r.count + 1'b1;
    end else if (pop && !push) begin
      q_nxt.count = q_r.count - 1'b1;
    end
    q_nxt.in_ready = (q_nxt.count != FULL_COUNT);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= '0;
      q_r.in_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign in_ready_o = q_r.in_ready;
  assign out_valid_o = (q_r.count != '0);
  assign out_data_o = q_r.mem[q_r.rd_ptr];
endmodule

// ********
// Common control and status
// ********
module usb_common_ctrl
  import usb_common_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter bit SOFT_CONN_SUPPORTED = 1'b1,
  parameter logic [15:0] HW_VERSION = 16'h0100, // Arbitrary value
  parameter logic [7:0] EP_INFO = 8'hff,
  parameter logic [7:0] RAM_INFO = 8'h00
) (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [9:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  input wire logic HOST_MODE_I,
  input wire logic A_DEVICE_I,
  input wire logic BUS_RESET_I,
  input wire logic HS_CHIRP_OK_I,
  input wire logic RESUME_DET_I,
  input wire logic SUSPEND_DET_I,
  input wire logic SUPPLY_DROP_I,
  input wire logic SESSION_REQ_I,
  input wire logic DISCONNECT_I,
  input wire logic SESSION_END_I,
  input wire logic CONNECT_I,
  input wire logic BABBLE_I,
  input wire logic SOF_I,
  input wire logic [10:0] FRAME_NUM_I,
  input wire logic TX_PACKET_LOADED_I,
  input wire logic IN_TOKEN_I,
  input wire logic EP_EVT_VALID_I,
  input wire logic EP_EVT_RX_I,
  input wire logic [3:0] EP_EVT_NUM_I,
  output logic EP_EVT_READY_O,
  output logic SEND_PACKET_O,
  output logic SEND_ZERO_LEN_O,
  output logic LINE_DRV_EN_O,
  output logic HIGH_SPEED_ALLOW_O,
  output logic RESUME_OUT_O,
  output logic PHY_SUSPEND_OUT_N_O,
  output logic IRQ_O
);
  if (FIFO_DEPTH < 2) begin : g_depth_check
    $error("FIFO_DEPTH must be at least 2");
  end

  typedef struct packed {
    logic [6:0] function_address;
    logic [7:0] power;
    logic [15:0] tx_flags;
    logic [15:0] rx_flags;
    logic [15:0] tx_en;
    logic [15:0] rx_en;
    logic [7:0] usb_flags;
    logic [7:0] usb_en;
    logic [FRAME_BITS-1:0] frame;
    logic [7:0] rx_fifo_size;
    logic [15:0] tx_fifo_start;
    logic [15:0] rx_fifo_start;
    logic [7:0] link_delay;
    logic [7:0] hs_eof;
    logic [7:0] fs_eof;
    logic [7:0] ls_eof;
    logic [ENDPOINTS-1:1][15:0] rq_count;
    logic bus_reset_q;
    logic sof_seen;
    logic iso_wait;
    logic [7:0] rdata;
    logic rvalid;
    logic send_pkt;
    logic send_zlp;
    logic line_drv;
    logic suspend_n;
    logic irq;
  } ctrl_s;

  ctrl_s q_r;
  ctrl_s q_nxt;
  logic evt_valid;
  logic evt_ready;
  logic [4:0] evt_data;
  logic flag_read;

  // Endpoint events queue here; draining stalls while software reads the flags
  usb_event_fifo #(
    .WIDTH(5),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(EP_EVT_VALID_I),
    .in_ready_o(EP_EVT_READY_O),
    .in_data_i({EP_EVT_RX_I, EP_EVT_NUM_I}),
    .out_valid_o(evt_valid),
    .out_ready_i(evt_ready),
    .out_data_o(evt_data)
  );

  // Byte lane of a 16-bit register
  function automatic logic [7:0] lane(input logic [15:0] v, input logic hi);
    lane = hi ? v[15:8] : v[7:0];
  endfunction

  // Next state of all registers
  always_comb begin
    logic [7:0] rd;
    logic [7:0] ev;
    logic rst_end;
    rd = '0;
    ev = '0;
    rst_end = 1'b0;
    q_nxt = q_r;
    flag_read = RD_I && (ADDR_I[9:1] == OFS_TX_FLAGS[9:1] ||
                         ADDR_I[9:1] == OFS_RX_FLAGS[9:1]);
    evt_ready = ~flag_read;
    // Read mux; clears follow below and lose to new sets
    unique case (ADDR_I)
      OFS_FUNCTION_ADDRESS: rd = {1'b0, q_r.function_address};
      OFS_POWER: rd = q_r.power;
      OFS_TX_FLAGS, OFS_TX_FLAGS + 10'h001: rd = lane(q_r.tx_flags, ADDR_I[0]);
      OFS_RX_FLAGS, OFS_RX_FLAGS + 10'h001: rd = lane(q_r.rx_flags, ADDR_I[0]);
      OFS_TX_EN, OFS_TX_EN + 10'h001: rd = lane(q_r.tx_en, ADDR_I[0]);
      OFS_RX_EN, OFS_RX_EN + 10'h001: rd = lane(q_r.rx_en, ADDR_I[0]);
      OFS_USB_FLAGS: rd = q_r.usb_flags;
      OFS_USB_EN: rd = q_r.usb_en;
      OFS_FRAME, OFS_FRAME + 10'h001: rd = lane(16'(q_r.frame), ADDR_I[0]);
      OFS_DEV_CTL: rd = 8'(HOST_MODE_I) << HOST_MODE_BIT;
      OFS_RX_FIFO_SIZE: rd = q_r.rx_fifo_size;
      OFS_TX_FIFO_START, OFS_TX_FIFO_START + 10'h001: rd = lane(q_r.tx_fifo_start, ADDR_I[0]);
      OFS_RX_FIFO_START, OFS_RX_FIFO_START + 10'h001: rd = lane(q_r.rx_fifo_start, ADDR_I[0]);
      OFS_HW_VERSION, OFS_HW_VERSION + 10'h001: rd = lane(HW_VERSION, ADDR_I[0]);
      OFS_EP_INFO: rd = EP_INFO;
      OFS_RAM_INFO: rd = RAM_INFO;
      OFS_LINK_DELAY: rd = q_r.link_delay;
      OFS_HS_EOF: rd = q_r.hs_eof;
      OFS_FS_EOF: rd = q_r.fs_eof;
      OFS_LS_EOF: rd = q_r.ls_eof;
      default: begin
        if (ADDR_I[9:5] == OFS_RQ_COUNT[9:5] && ADDR_I[4:1] != 4'h0) begin
          rd = lane(q_r.rq_count[ADDR_I[4:1]], ADDR_I[0]);
        end
      end
    endcase
    q_nxt.rvalid = RD_I;
    if (RD_I) begin
      q_nxt.rdata = rd;
    end
    // Flag registers clear on read, one byte lane at a time
    if (RD_I && ADDR_I == OFS_TX_FLAGS) q_nxt.tx_flags[7:0] = '0;
    if (RD_I && ADDR_I == OFS_TX_FLAGS + 10'h001) q_nxt.tx_flags[15:8] = '0;
    if (RD_I && ADDR_I == OFS_RX_FLAGS) q_nxt.rx_flags[7:0] = '0;
    if (RD_I && ADDR_I == OFS_RX_FLAGS + 10'h001) q_nxt.rx_flags[15:8] = '0;
    if (RD_I && ADDR_I == OFS_USB_FLAGS) begin
      q_nxt.usb_flags = '0;
      q_nxt.power[PWR_SUSPEND_MODE] = 1'b0;
    end
    // Register writes
    if (WR_I) begin
      unique case (ADDR_I)
        OFS_FUNCTION_ADDRESS: q_nxt.function_address = WDATA_I[6:0];
        OFS_POWER: begin
          q_nxt.power[PWR_ISO_UPDATE] = WDATA_I[PWR_ISO_UPDATE];
          q_nxt.power[PWR_SOFT_CONN] = WDATA_I[PWR_SOFT_CONN];
          q_nxt.power[PWR_HIGH_SPEED_ALLOW] = WDATA_I[PWR_HIGH_SPEED_ALLOW];
          q_nxt.power[PWR_RESUME] = WDATA_I[PWR_RESUME];
          q_nxt.power[PWR_SUSPEND_OUTPUT_ENABLE] = WDATA_I[PWR_SUSPEND_OUTPUT_ENABLE];
          if (HOST_MODE_I && WDATA_I[PWR_SUSPEND_MODE]) begin
            q_nxt.power[PWR_SUSPEND_MODE] = 1'b1;
          end
          if (WDATA_I[PWR_RESUME]) begin
            q_nxt.power[PWR_SUSPEND_MODE] = 1'b0;
          end
        end
        OFS_TX_EN: q_nxt.tx_en[7:0] = WDATA_I;
        OFS_TX_EN + 10'h001: q_nxt.tx_en[15:8] = WDATA_I;
        OFS_RX_EN: q_nxt.rx_en[7:0] = {WDATA_I[7:1], 1'b0};
        OFS_RX_EN + 10'h001: q_nxt.rx_en[15:8] = WDATA_I;
        OFS_USB_EN: q_nxt.usb_en = WDATA_I;
        OFS_RX_FIFO_SIZE: q_nxt.rx_fifo_size = WDATA_I;
        OFS_TX_FIFO_START: q_nxt.tx_fifo_start[7:0] = WDATA_I;
        OFS_TX_FIFO_START + 10'h001: q_nxt.tx_fifo_start[15:8] = WDATA_I;
        OFS_RX_FIFO_START: q_nxt.rx_fifo_start[7:0] = WDATA_I;
        OFS_RX_FIFO_START + 10'h001: q_nxt.rx_fifo_start[15:8] = WDATA_I;
        OFS_LINK_DELAY: q_nxt.link_delay = WDATA_I;
        OFS_HS_EOF: q_nxt.hs_eof = WDATA_I;
        OFS_FS_EOF: q_nxt.fs_eof = WDATA_I;
        OFS_LS_EOF: q_nxt.ls_eof = WDATA_I;
        default: begin
          if (ADDR_I[9:5] == OFS_RQ_COUNT[9:5] && ADDR_I[4:1] != 4'h0) begin
            q_nxt.rq_count[ADDR_I[4:1]][{ADDR_I[0], 3'h0} +: 8] = WDATA_I;
          end
        end
      endcase
    end
    // Endpoint events from the FIFO set flags after any clear
    if (evt_valid && evt_ready) begin
      if (!evt_data[4]) begin
        q_nxt.tx_flags[evt_data[3:0]] = 1'b1;
      end else if (evt_data[3:0] != 4'h0) begin
        q_nxt.rx_flags[evt_data[3:0]] = 1'b1;
      end
    end
    // Bus reset tracking and high speed result
    q_nxt.bus_reset_q = BUS_RESET_I;
    q_nxt.power[PWR_RESET] = BUS_RESET_I;
    rst_end = q_r.bus_reset_q & ~BUS_RESET_I;
    if (rst_end) begin
      q_nxt.power[PWR_HIGH_SPEED_ACTIVE] = HS_CHIRP_OK_I &
                                            q_r.power[PWR_HIGH_SPEED_ALLOW];
    end
    if (SESSION_END_I || DISCONNECT_I) begin
      q_nxt.power[PWR_HIGH_SPEED_ACTIVE] = 1'b0;
    end
    // Suspend and resume from the line
    if (!HOST_MODE_I && SUSPEND_DET_I) begin
      q_nxt.power[PWR_SUSPEND_MODE] = 1'b1;
    end
    if (HOST_MODE_I && RESUME_DET_I && q_r.power[PWR_SUSPEND_MODE]) begin
      q_nxt.power[PWR_RESUME] = 1'b1;
    end
    // Babble is armed only once a frame has been sent
    if (BUS_RESET_I || !HOST_MODE_I) begin
      q_nxt.sof_seen = 1'b0;
    end else if (SOF_I) begin
      q_nxt.sof_seen = 1'b1;
    end
    // Common bus events; sets win over the read clear
    ev[EVT_SUPPLY_DROP] = SUPPLY_DROP_I & A_DEVICE_I;
    ev[EVT_SESSION_REQ] = SESSION_REQ_I & A_DEVICE_I;
    ev[EVT_DISCONNECT] = HOST_MODE_I ? DISCONNECT_I : SESSION_END_I;
    ev[EVT_CONNECT] = HOST_MODE_I & CONNECT_I;
    ev[EVT_SOF] = SOF_I;
    ev[EVT_RESET_BABBLE] = HOST_MODE_I ? (BABBLE_I & q_r.sof_seen)
                                       : (BUS_RESET_I & ~q_r.bus_reset_q);
    ev[EVT_RESUME] = RESUME_DET_I & q_r.power[PWR_SUSPEND_MODE];
    ev[EVT_SUSPEND] = SUSPEND_DET_I & ~HOST_MODE_I;
    q_nxt.usb_flags = q_nxt.usb_flags | ev;
    // Frame number capture
    if (SOF_I) begin
      q_nxt.frame = FRAME_NUM_I;
    end
    // Isochronous hold: packet waits for SOF, IN before it gets zero length
    if (TX_PACKET_LOADED_I && q_r.power[PWR_ISO_UPDATE]) begin
      q_nxt.iso_wait = 1'b1;
    end
    if (SOF_I || !q_r.power[PWR_ISO_UPDATE]) begin
      q_nxt.iso_wait = 1'b0;
    end
    q_nxt.send_zlp = IN_TOKEN_I & q_r.iso_wait;
    q_nxt.send_pkt = IN_TOKEN_I & ~q_r.iso_wait;
    // Pin level outputs
    q_nxt.line_drv = SOFT_CONN_SUPPORTED & q_nxt.power[PWR_SOFT_CONN];
    q_nxt.suspend_n = ~(q_nxt.power[PWR_SUSPEND_OUTPUT_ENABLE] &
                        q_nxt.power[PWR_SUSPEND_MODE]);
    q_nxt.irq = |(q_nxt.tx_flags & q_nxt.tx_en) |
                |(q_nxt.rx_flags & q_nxt.rx_en) |
                |(q_nxt.usb_flags & q_nxt.usb_en);
  end

  // Reset values of every register
  localparam ctrl_s RST_STATE = '{function_address: RST_FUNCTION_ADDRESS, power: RST_POWER, tx_en: RST_TX_EN,
    rx_en: RST_RX_EN, usb_en: RST_USB_EN, link_delay: RST_LINK_DELAY, hs_eof: RST_HS_EOF,
    fs_eof: RST_FS_EOF, ls_eof: RST_LS_EOF, rq_count: {(ENDPOINTS - 1){RST_RQ_COUNT}},
    suspend_n: 1'b1, default: '0};

  // State register
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      q_r <= RST_STATE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign RDATA_O = q_r.rdata;
  assign RVALID_O = q_r.rvalid;
  assign SEND_PACKET_O = q_r.send_pkt;
  assign SEND_ZERO_LEN_O = q_r.send_zlp;
  assign LINE_DRV_EN_O = q_r.line_drv;
  assign HIGH_SPEED_ALLOW_O = q_r.power[PWR_HIGH_SPEED_ALLOW];
  assign RESUME_OUT_O = q_r.power[PWR_RESUME];
  assign PHY_SUSPEND_OUT_N_O = q_r.suspend_n;
  assign IRQ_O = q_r.irq;
endmodule

// [rtl/usb_common_pkg.sv]
package usb_common_pkg;
  // ********
  // Register byte offsets
  // ********
  localparam logic [9:0] OFS_FUNCTION_ADDRESS = 10'h000;
  localparam logic [9:0] OFS_POWER = 10'h001;
  localparam logic [9:0] OFS_TX_FLAGS = 10'h002;
  localparam logic [9:0] OFS_RX_FLAGS = 10'h004;
  localparam logic [9:0] OFS_TX_EN = 10'h006;
  localparam logic [9:0] OFS_RX_EN = 10'h008;
  localparam logic [9:0] OFS_USB_FLAGS = 10'h00a;
  localparam logic [9:0] OFS_USB_EN = 10'h00b;
  localparam logic [9:0] OFS_FRAME = 10'h00c;
  localparam logic [9:0] OFS_DEV_CTL = 10'h060;
  localparam logic [9:0] OFS_RX_FIFO_SIZE = 10'h063;
  localparam logic [9:0] OFS_TX_FIFO_START = 10'h064;
  localparam logic [9:0] OFS_RX_FIFO_START = 10'h066;
  localparam logic [9:0] OFS_HW_VERSION = 10'h06c;
  localparam logic [9:0] OFS_EP_INFO = 10'h078;
  localparam logic [9:0] OFS_RAM_INFO = 10'h079;
  localparam logic [9:0] OFS_LINK_DELAY = 10'h07a;
  localparam logic [9:0] OFS_HS_EOF = 10'h07c;
  localparam logic [9:0] OFS_FS_EOF = 10'h07d;
  localparam logic [9:0] OFS_LS_EOF = 10'h07e;
  localparam logic [9:0] OFS_RQ_COUNT = 10'h300;
  // ********
  // Reset values
  // ********
  localparam logic [6:0] RST_FUNCTION_ADDRESS = 7'h00;
  localparam logic [7:0] RST_POWER = 8'h20;
  localparam logic [15:0] RST_TX_EN = 16'hffff;
  localparam logic [15:0] RST_RX_EN = 16'hfffe;
  localparam logic [7:0] RST_USB_EN = 8'h06;
  localparam logic [7:0] RST_LINK_DELAY = 8'h5c;
  localparam logic [7:0] RST_HS_EOF = 8'h80;
  localparam logic [7:0] RST_FS_EOF = 8'h00;
  localparam logic [7:0] RST_LS_EOF = 8'h72;
  localparam logic [15:0] RST_RQ_COUNT = 16'h0000;
  // ********
  // Power register bit positions
  // ********
  localparam int PWR_ISO_UPDATE = 7;
  localparam int PWR_SOFT_CONN = 6;
  localparam int PWR_HIGH_SPEED_ALLOW = 5;
  localparam int PWR_HIGH_SPEED_ACTIVE = 4;
  localparam int PWR_RESET = 3;
  localparam int PWR_RESUME = 2;
  localparam int PWR_SUSPEND_MODE = 1;
  localparam int PWR_SUSPEND_OUTPUT_ENABLE = 0;
  // ********
  // Common bus event flag positions
  // ********
  localparam int EVT_SUPPLY_DROP = 7;
  localparam int EVT_SESSION_REQ = 6;
  localparam int EVT_DISCONNECT = 5;
  localparam int EVT_CONNECT = 4;
  localparam int EVT_SOF = 3;
  localparam int EVT_RESET_BABBLE = 2;
  localparam int EVT_RESUME = 1;
  localparam int EVT_SUSPEND = 0;
  // ********
  // Sizes
  // ********
  localparam int ENDPOINTS = 16;
  localparam int FRAME_BITS = 11;
  localparam int HOST_MODE_BIT = 2;
endpackage
